// ### dcp_pad_model.sv
// pad model for the timer: capture inputs A and B, pwm output observer
// assumes the bench calls set() from its main thread between bus cycles

module dcp_pad_model (
  input wire logic clock,
  input wire logic pin_out,
  input wire logic oe_n,
  output logic a_in,
  output logic b_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic a_drv = 1'b0;
  logic b_drv = 1'b0;
  logic last = 1'b0;
  int toggles = 0;

  // the pad shows the device level only while the device drives it
  assign a_in = oe_n ? a_drv : pin_out;
  assign b_in = b_drv;

  always @(posedge clock) begin
    if (oe_n === 1'b0 && pin_out !== last) toggles++;
    last = pin_out;
  end

  // each level is held two cycles, longer than the one-cycle minimum
  task set(input logic a, input logic b);
    @(posedge clock);
    a_drv <= a;
    b_drv <= b;
    repeat (2) @(posedge clock);
  endtask

  task clear;
    toggles = 0;
  endtask
endmodule

// ### dcp_pkg.sv
// constants, field layouts and state types of the dual counter pwm / capture timer
// assumes a single 250 MHz system clock and an axi4-lite register master

package dcp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned 32-bit word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_MASK = 8'hFC;
  localparam logic [7:0] OFS_COUNTER_ONE = 8'h00;
  localparam logic [7:0] OFS_RELOAD_CAPTURE_A = 8'h04;
  localparam logic [7:0] OFS_RELOAD_CAPTURE_B = 8'h08;
  localparam logic [7:0] OFS_COUNTER_TWO = 8'h0C;
  localparam logic [7:0] OFS_MODE_CONTROL_REG = 8'h10;
  localparam logic [7:0] OFS_CLOCK_SELECT_REG = 8'h14;
  localparam logic [7:0] OFS_PRESCALE_REG = 8'h18;
  localparam logic [7:0] OFS_PENDING_REG = 8'h1C;

  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int MCTRL_W = 15;
  localparam int MCTRL_OUT_BIT = 5;
  localparam int SEL1_LSB = 0;
  localparam int SEL2_LSB = 3;
  localparam int PEND_A = 0;
  localparam int PEND_B = 1;
  localparam int PEND_C = 2;
  localparam int PEND_D = 3;
  localparam logic [1:0] MODE_PWM = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [2:0] CKS_NONE = 3'h0;
  localparam logic [2:0] CKS_PRESCALED = 3'h1;
  localparam logic [2:0] CKS_EXT_EVENT = 3'h2;
  localparam logic [2:0] CKS_PULSE_ACC = 3'h3;
  localparam logic [2:0] CKS_SLOW = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sw_trigger_go;
    logic counter_two_irq_enable;
    logic irq_enable_underflow_one;
    logic irq_enable_b;
    logic irq_enable_a;
    logic preset_on_capture_b;
    logic preset_on_capture_a;
    logic edge_select_b;
    logic edge_select_a;
    logic initial_out_level;
    logic timer_enable_bit;
    logic sw_trigger_select;
    logic pulse_train_enable;
    logic [1:0] mode_select_field;
  } dcp_mctrl_s;

  typedef struct packed {
    logic [15:0] counter_one;
    logic [15:0] counter_two;
    logic [15:0] reload_capture_a;
    logic [15:0] reload_capture_b;
    dcp_mctrl_s mctrl;
    logic [2:0] sel1;
    logic [2:0] sel2;
    logic [7:0] presc;
    logic [7:0] pcnt;
    logic [3:0] pend;
    logic out_lvl;
    logic a_oe_n;
    logic next_b;
    logic train_on;
    logic a_prev;
    logic b_prev;
    logic slow;
    logic irq1;
    logic irq2;
    logic awrdy;
    logic wrdy;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dcp_state_s;

  localparam dcp_state_s STATE_RESET = '{awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1,
                                         a_oe_n: 1'b1, default: '0};

endpackage

// ### dcp_timer.sv
// dual 16-bit counter timer: pwm, pwm pulse train and dual-input capture
// assumes pins already synchronous to CLOCK and an axi4-lite master on the bus side
//
// Function
// - pwm: counter one counts down, reloads alternately from A then B on underflow.
// - first start counts down from the value software wrote into counter one.
// - pwm: channel A output toggles on every counter one underflow.
// - initial level bit sets pwm starting level, so which reload is high phase.
// - any restart of counter one makes its first reload come from A.
// - reload from A or B sets its pending flag; separate enabled interrupts.
// - pwm: counter two is a system/event timer; underflow irq only when enabled.
// - pulse-train mode is pwm mode plus the pulse-train enable bit.
// - pulse train: underflows toggle output; each pulse end decrements counter two.
// - pulse train: counter two underflow at end of pulse stops counter one clock.
// - pulse train: counter two underflow presets it to zero, never reloads.
// - pulse train emits counter two value plus one pulses.
// - pulse train starts on channel B edge or on the software trigger bit.
// - timer is disabled out of reset; each pulse-train entry reloads from A first.
// - capture: channel A edge copies counter one to A, channel B edge to B.
// - each channel edge independently selects rising or falling.
// - preset enabled: capture stores counter first, then presets counter one to all ones.
// - capture: separate A/B capture irq enables; underflow one irq when enabled.
// - capture: counter two is a system timer with enabled underflow irq.
// - capture: event or pulse-accumulate clock stops counter one; counter two takes any.

module dcp_timer (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [dcp_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [dcp_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic CHANNEL_A_PIN_IN,
  output logic CHANNEL_A_PIN_OUT,
  output logic CHANNEL_A_PIN_OE_N,
  input wire logic CHANNEL_B_PIN_IN,
  output logic IRQ_ONE,
  output logic IRQ_TWO
);
  import dcp_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // rising edge when sel is set, falling edge otherwise
  function automatic logic edge_hit(input logic sel, input logic now, input logic prev);
    return sel ? (now & ~prev) : (~now & prev);
  endfunction

  function automatic logic src_tick(input logic [2:0] sel, input logic ptk,
                                    input logic bedge, input logic blvl, input logic slw);
    logic t;
    t = 1'b0;
    case (sel)
      CKS_PRESCALED: t = ptk;
      CKS_EXT_EVENT: t = bedge;
      CKS_PULSE_ACC: t = ptk & blvl;
      CKS_SLOW: t = slw;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // ----------------------------------------------------------------
  // state and derived terms
  // ----------------------------------------------------------------
  dcp_state_s s_reg;
  dcp_state_s s_next;
  logic en, pwm, train, capture, ptick, a_edge, b_edge;
  logic c1_ok, run1, tick1, uf1, back_init, tick2, uf2, restart1, start, wr_go;
  logic [7:0] waddr;

  assign en = s_reg.mctrl.timer_enable_bit;
  assign pwm = (s_reg.mctrl.mode_select_field == MODE_PWM);
  assign train = pwm & s_reg.mctrl.pulse_train_enable;
  assign capture = (s_reg.mctrl.mode_select_field == MODE_CAPTURE);
  assign ptick = (s_reg.pcnt == s_reg.presc);
  // inputs held a full cycle are seen by the one-cycle-old copy
  assign a_edge = edge_hit(s_reg.mctrl.edge_select_a, CHANNEL_A_PIN_IN, s_reg.a_prev);
  assign b_edge = edge_hit(s_reg.mctrl.edge_select_b, CHANNEL_B_PIN_IN, s_reg.b_prev);
  // channel B is a capture input in capture mode, so event clocks make no sense there
  assign c1_ok = !(capture && (s_reg.sel1 == CKS_EXT_EVENT || s_reg.sel1 == CKS_PULSE_ACC));
  assign run1 = en & (pwm | capture) & c1_ok & (!train | s_reg.train_on);
  assign tick1 = run1 & src_tick(s_reg.sel1, ptick, b_edge, CHANNEL_B_PIN_IN, s_reg.slow);
  assign uf1 = tick1 & (s_reg.counter_one == CNT_ZERO);
  // after this toggle the pad is back at its initial level: a pulse has ended
  assign back_init = (~s_reg.out_lvl == s_reg.mctrl.initial_out_level);
  assign tick2 = train ? (uf1 & back_init) :
                 (en & (pwm | capture) &
                  src_tick(s_reg.sel2, ptick, b_edge, CHANNEL_B_PIN_IN, s_reg.slow));
  assign uf2 = tick2 & (s_reg.counter_two == CNT_ZERO);
  assign restart1 = !en | (s_reg.sel1 == CKS_NONE) | !pwm;
  assign start = train & en & !s_reg.train_on &
                 (s_reg.mctrl.sw_trigger_select ? s_reg.mctrl.sw_trigger_go : b_edge);
  assign wr_go = s_reg.aw_have & s_reg.w_have & ~s_reg.bvalid;
  assign waddr = s_reg.awaddr & ADDR_MASK;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] pset;
    logic [3:0] pclr;
    logic [31:0] wv;
    logic [7:0] raddr;
    pset = 4'h0;
    pclr = 4'h0;
    wv = 32'h0000_0000;
    raddr = S_AXI_ARADDR & ADDR_MASK;
    s_next = s_reg;
    s_next.mctrl.sw_trigger_go = 1'b0;
    s_next.a_prev = CHANNEL_A_PIN_IN;
    s_next.b_prev = CHANNEL_B_PIN_IN;
    s_next.slow = ~s_reg.slow;
    s_next.pcnt = ptick ? 8'h00 : s_reg.pcnt + 8'h01;

    // counter one: decrement from the preloaded value, act on underflow
    if (restart1) begin
      s_next.next_b = 1'b0;
    end
    if (tick1) begin
      if (s_reg.counter_one != CNT_ZERO) begin
        s_next.counter_one = s_reg.counter_one - 16'h0001;
      end else if (pwm) begin
        s_next.counter_one = s_reg.next_b ? s_reg.reload_capture_b
                                          : s_reg.reload_capture_a;
        s_next.next_b = ~s_reg.next_b;
        s_next.out_lvl = ~s_reg.out_lvl;
        pset[s_reg.next_b ? PEND_B : PEND_A] = 1'b1;
      end else begin
        s_next.counter_one = CNT_MAX;
        pset[PEND_C] = 1'b1;
      end
    end

    // counter two: free timer, or pulse counter in pulse-train mode
    if (tick2) begin
      if (!uf2) begin
        s_next.counter_two = s_reg.counter_two - 16'h0001;
      end else begin
        s_next.counter_two = train ? CNT_ZERO : CNT_MAX;
        pset[PEND_D] = 1'b1;
      end
    end

    // pulse train gate; underflow of counter two only occurs at a pulse end
    if (!train || !en || (train && uf2)) begin
      s_next.train_on = 1'b0;
    end else if (start) begin
      s_next.train_on = 1'b1;
      s_next.next_b = 1'b0;
    end

    // dual capture: store first, then optional preset
    if (capture && en) begin
      if (a_edge) begin
        s_next.reload_capture_a = s_reg.counter_one;
        pset[PEND_A] = 1'b1;
        if (s_reg.mctrl.preset_on_capture_a) begin
          s_next.counter_one = CNT_MAX;
        end
      end
      if (b_edge) begin
        s_next.reload_capture_b = s_reg.counter_one;
        pset[PEND_B] = 1'b1;
        if (s_reg.mctrl.preset_on_capture_b) begin
          s_next.counter_one = CNT_MAX;
        end
      end
    end

    // axi write: address and data taken in either order
    if (S_AXI_AWVALID && s_reg.awrdy) begin
      s_next.awaddr = S_AXI_AWADDR;
      s_next.aw_have = 1'b1;
      s_next.awrdy = 1'b0;
    end
    if (S_AXI_WVALID && s_reg.wrdy) begin
      s_next.wdata = S_AXI_WDATA;
      s_next.wstrb = S_AXI_WSTRB;
      s_next.w_have = 1'b1;
      s_next.wrdy = 1'b0;
    end
    if (wr_go) begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      // software writes win over counting in the same cycle
      if (waddr == OFS_COUNTER_ONE) begin
        wv = merge_bytes({16'h0000, s_reg.counter_one}, s_reg.wdata, s_reg.wstrb);
        s_next.counter_one = wv[15:0];
      end else if (waddr == OFS_RELOAD_CAPTURE_A) begin
        wv = merge_bytes({16'h0000, s_reg.reload_capture_a}, s_reg.wdata, s_reg.wstrb);
        s_next.reload_capture_a = wv[15:0];
      end else if (waddr == OFS_RELOAD_CAPTURE_B) begin
        wv = merge_bytes({16'h0000, s_reg.reload_capture_b}, s_reg.wdata, s_reg.wstrb);
        s_next.reload_capture_b = wv[15:0];
      end else if (waddr == OFS_COUNTER_TWO) begin
        wv = merge_bytes({16'h0000, s_reg.counter_two}, s_reg.wdata, s_reg.wstrb);
        s_next.counter_two = wv[15:0];
      end else if (waddr == OFS_MODE_CONTROL_REG) begin
        wv = merge_bytes({17'h00000, s_reg.mctrl}, s_reg.wdata, s_reg.wstrb);
        s_next.mctrl = dcp_mctrl_s'(wv[MCTRL_W-1:0]);
        // the bit is both the starting and the present pad level
        s_next.out_lvl = wv[MCTRL_OUT_BIT];
        if (wv[2] != s_reg.mctrl.pulse_train_enable) begin
          s_next.next_b = 1'b0;
        end
      end else if (waddr == OFS_CLOCK_SELECT_REG) begin
        wv = merge_bytes({26'h0000000, s_reg.sel2, s_reg.sel1}, s_reg.wdata, s_reg.wstrb);
        s_next.sel1 = wv[SEL1_LSB +: 3];
        s_next.sel2 = wv[SEL2_LSB +: 3];
      end else if (waddr == OFS_PRESCALE_REG) begin
        wv = merge_bytes({24'h000000, s_reg.presc}, s_reg.wdata, s_reg.wstrb);
        s_next.presc = wv[7:0];
      end else if (waddr == OFS_PENDING_REG) begin
        pclr = s_reg.wdata[3:0] & {4{s_reg.wstrb[0]}};
      end else begin
        s_next.bresp = RESP_SLVERR;
      end
    end
    if (s_reg.bvalid && S_AXI_BREADY) begin
      s_next.bvalid = 1'b0;
      s_next.awrdy = 1'b1;
      s_next.wrdy = 1'b1;
    end

    // axi read: answered one cycle after the address is taken
    if (S_AXI_ARVALID && s_reg.arrdy) begin
      s_next.arrdy = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      if (raddr == OFS_COUNTER_ONE) begin
        s_next.rdata = {16'h0000, s_reg.counter_one};
      end else if (raddr == OFS_RELOAD_CAPTURE_A) begin
        s_next.rdata = {16'h0000, s_reg.reload_capture_a};
      end else if (raddr == OFS_RELOAD_CAPTURE_B) begin
        s_next.rdata = {16'h0000, s_reg.reload_capture_b};
      end else if (raddr == OFS_COUNTER_TWO) begin
        s_next.rdata = {16'h0000, s_reg.counter_two};
      end else if (raddr == OFS_MODE_CONTROL_REG) begin
        s_next.rdata = {17'h00000, s_reg.mctrl};
      end else if (raddr == OFS_CLOCK_SELECT_REG) begin
        s_next.rdata = {26'h0000000, s_reg.sel2, s_reg.sel1};
      end else if (raddr == OFS_PRESCALE_REG) begin
        s_next.rdata = {24'h000000, s_reg.presc};
      end else if (raddr == OFS_PENDING_REG) begin
        s_next.rdata = {27'h0000000, s_reg.train_on, s_reg.pend};
      end else begin
        s_next.rdata = 32'h0000_0000;
        s_next.rresp = RESP_SLVERR;
      end
    end
    if (s_reg.rvalid && S_AXI_RREADY) begin
      s_next.rvalid = 1'b0;
      s_next.arrdy = 1'b1;
    end

    // sticky flags: a set in the clearing cycle survives
    s_next.pend = (s_reg.pend & ~pclr) | pset;
    s_next.irq1 = |(s_next.pend[PEND_C:PEND_A] &
                    {s_next.mctrl.irq_enable_underflow_one, s_next.mctrl.irq_enable_b,
                     s_next.mctrl.irq_enable_a});
    s_next.irq2 = s_next.pend[PEND_D] & s_next.mctrl.counter_two_irq_enable;
    s_next.a_oe_n = !((s_next.mctrl.mode_select_field == MODE_PWM) &&
                      s_next.mctrl.preset_on_capture_a);
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY = s_reg.awrdy;
  assign S_AXI_WREADY = s_reg.wrdy;
  assign S_AXI_BVALID = s_reg.bvalid;
  assign S_AXI_BRESP = s_reg.bresp;
  assign S_AXI_ARREADY = s_reg.arrdy;
  assign S_AXI_RVALID = s_reg.rvalid;
  assign S_AXI_RDATA = s_reg.rdata;
  assign S_AXI_RRESP = s_reg.rresp;
  assign CHANNEL_A_PIN_OUT = s_reg.out_lvl;
  assign CHANNEL_A_PIN_OE_N = s_reg.a_oe_n;
  assign IRQ_ONE = s_reg.irq1;
  assign IRQ_TWO = s_reg.irq2;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  sequence seq_pwm_uf;
    pwm && uf1 && !wr_go;
  endsequence
  sequence seq_train_end;
    train && uf2;
  endsequence

  AST_RELOAD_VALUE: assert property (seq_pwm_uf |=> s_reg.counter_one ==
    ($past(s_reg.next_b) ? $past(s_reg.reload_capture_b) : $past(s_reg.reload_capture_a)))
    else $error("counter one reloaded with wrong value");
  AST_TOGGLE: assert property (seq_pwm_uf |=> s_reg.out_lvl != $past(s_reg.out_lvl))
    else $error("pwm output did not toggle on underflow");
  AST_INIT_LEVEL: assert property (wr_go && waddr == OFS_MODE_CONTROL_REG && s_reg.wstrb[0]
    |=> s_reg.out_lvl == $past(s_reg.wdata[MCTRL_OUT_BIT]))
    else $error("pwm level not set from initial level bit");
  AST_RESTART_A: assert property (restart1 ##1 !restart1 |-> !s_reg.next_b)
    else $error("restart did not select reload A first");
  AST_RELOAD_FLAG: assert property (pwm && uf1 |=>
    ($past(s_reg.next_b) ? s_reg.pend[PEND_B] : s_reg.pend[PEND_A]))
    else $error("reload pending flag not set");
  AST_C2_IRQ_GATE: assert property (!s_reg.mctrl.counter_two_irq_enable [*2] |-> !IRQ_TWO)
    else $error("counter two irq without enable");
  AST_TRAIN_MODE: assert property (s_reg.train_on |-> $past(train))
    else $error("train running outside pulse-train mode");
  AST_TRAIN_DEC: assert property (train && tick2 && !uf2 && !wr_go
    |=> s_reg.counter_two == $past(s_reg.counter_two) - 16'h0001)
    else $error("pulse count not decremented");
  AST_TRAIN_STOP: assert property (seq_train_end |=> !s_reg.train_on ##1 !tick1)
    else $error("counter one clock not stopped at train end");
  AST_PRESET_ZERO: assert property (seq_train_end ##0 !wr_go |=> s_reg.counter_two == CNT_ZERO)
    else $error("counter two not preset to zero");
  AST_START: assert property (start |=> s_reg.train_on)
    else $error("pulse train did not start");
  AST_CAPTURE_A: assert property (capture && en && a_edge && !wr_go
    |=> s_reg.reload_capture_a == $past(s_reg.counter_one))
    else $error("capture A missed counter value");
  AST_PRESET_ONE: assert property (capture && en && b_edge && s_reg.mctrl.preset_on_capture_b
    && !wr_go |=> s_reg.counter_one == CNT_MAX)
    else $error("counter one not preset after capture");
  AST_STOP_C1: assert property (capture && s_reg.sel1 == CKS_EXT_EVENT && !a_edge && !b_edge
    && !wr_go |=> $stable(s_reg.counter_one))
    else $error("counter one ran on event clock in capture mode");
  AST_PEND_STICKY: assert property (s_reg.pend[PEND_D]
    && !(wr_go && waddr == OFS_PENDING_REG) |=> s_reg.pend[PEND_D])
    else $error("pending flag dropped without a clear");

endmodule

// ### dual_counter_pwm_pulse_train_capture_test.sv
// self-checking bench for dcp_timer: axi4-lite master, pwm, pulse train, capture
// assumes dcp_pkg register map and the pad model in dcp_pad_model.sv

module dual_counter_pwm_pulse_train_capture_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dcp_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd_v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_out, oe_n, a_in, b_in, irq_one, irq_two;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  int err_count = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h6;
  logic [15:0] n;

  initial begin
    forever #2 clock = ~clock;
  end

  dcp_timer i_dut (.CLOCK(clock), .NRST(nrst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CHANNEL_A_PIN_IN(a_in), .CHANNEL_A_PIN_OUT(pin_out),
    .CHANNEL_A_PIN_OE_N(oe_n), .CHANNEL_B_PIN_IN(b_in), .IRQ_ONE(irq_one), .IRQ_TWO(irq_two));

  dcp_pad_model i_pad (.clock(clock), .pin_out(pin_out), .oe_n(oe_n), .a_in(a_in),
    .b_in(b_in));

  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction

  // a train of cnt+1 pulses shows two pin edges per pulse
  function int edges_for(input logic [15:0] cnt);
    return 2 * (int'(cnt) + 1);
  endfunction

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_v = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog: all tests need a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    give_verdict;
  end

  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    rd(OFS_MODE_CONTROL_REG, RESP_OKAY);
    chk("mode_control_reg", 32'h0, rd_v);
    rd(8'h20, RESP_SLVERR);
    chk("unmapped", 32'h0, rd_v);
    wr(8'h24, 32'h1, RESP_SLVERR);
    seed = xs(seed);
    wr(OFS_RELOAD_CAPTURE_A, seed, RESP_OKAY);
    rd(OFS_RELOAD_CAPTURE_A, RESP_OKAY);
    chk("reload_capture_a", {16'h0, seed[15:0]}, rd_v);
    // only byte one may change under a partial strobe
    wstrb <= 4'h2;
    wr(OFS_RELOAD_CAPTURE_A, 32'hFFFF_FFFF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFS_RELOAD_CAPTURE_A, RESP_OKAY);
    chk("byte_strobe", {16'h0, 8'hFF, seed[7:0]}, rd_v);
    $display("test registers done");
    // ------------------------------------------------------------
    // pwm: enable, output on, irq A on
    // ------------------------------------------------------------
    wr(OFS_COUNTER_ONE, 32'h3, RESP_OKAY);
    wr(OFS_RELOAD_CAPTURE_A, 32'h2, RESP_OKAY);
    wr(OFS_RELOAD_CAPTURE_B, 32'h5, RESP_OKAY);
    wr(OFS_MODE_CONTROL_REG, 32'h530, RESP_OKAY);
    chk("init_level", 32'h1, {31'h0, pin_out});
    // the level change above is not a pwm toggle
    i_pad.clear();
    wr(OFS_CLOCK_SELECT_REG, 32'h1, RESP_OKAY);
    do rd(OFS_PENDING_REG, RESP_OKAY); while (rd_v[1:0] !== 2'b11);
    @(posedge clock);
    chk("irq_one", 32'h1, {31'h0, irq_one});
    chk("toggled", 32'h1, {31'h0, i_pad.toggles > 0});
    wr(OFS_CLOCK_SELECT_REG, 32'h0, RESP_OKAY);
    wr(OFS_PENDING_REG, 32'h3, RESP_OKAY);
    rd(OFS_PENDING_REG, RESP_OKAY);
    chk("pend_cleared", 32'h0, rd_v & 32'h3);
    $display("test pwm done");
    // ------------------------------------------------------------
    // pulse train with software start, random pulse count
    // ------------------------------------------------------------
    wr(OFS_MODE_CONTROL_REG, 32'h0, RESP_OKAY);
    seed = xs(seed);
    n = {14'h0, seed[1:0]} + 16'h1;
    wr(OFS_COUNTER_ONE, 32'h2, RESP_OKAY);
    wr(OFS_RELOAD_CAPTURE_A, 32'h1, RESP_OKAY);
    wr(OFS_RELOAD_CAPTURE_B, 32'h1, RESP_OKAY);
    wr(OFS_COUNTER_TWO, {16'h0, n}, RESP_OKAY);
    wr(OFS_CLOCK_SELECT_REG, 32'h1, RESP_OKAY);
    i_pad.clear();
    wr(OFS_MODE_CONTROL_REG, 32'h11C, RESP_OKAY);
    wr(OFS_MODE_CONTROL_REG, 32'h411C, RESP_OKAY);
    do rd(OFS_PENDING_REG, RESP_OKAY); while (rd_v[4] !== 1'b0);
    chk("train_edges", 32'(edges_for(n)), 32'(i_pad.toggles));
    chk("pend_d", 32'h1, {31'h0, rd_v[3]});
    chk("irq_two", 32'h0, {31'h0, irq_two});
    rd(OFS_COUNTER_TWO, RESP_OKAY);
    chk("counter_two", 32'h0, rd_v);
    // corner case: zero loaded, started by a rising channel B edge
    wr(OFS_COUNTER_TWO, 32'h0, RESP_OKAY);
    i_pad.clear();
    wr(OFS_MODE_CONTROL_REG, 32'h194, RESP_OKAY);
    i_pad.set(1'b0, 1'b1);
    do rd(OFS_PENDING_REG, RESP_OKAY); while (rd_v[4] !== 1'b0);
    chk("train_b_edges", 32'(edges_for(16'h0)), 32'(i_pad.toggles));
    $display("test pulse train done");
    // ------------------------------------------------------------
    // capture: A rising with preset, B falling, counter one held
    // ------------------------------------------------------------
    wr(OFS_MODE_CONTROL_REG, 32'h2000, RESP_OKAY);
    chk("irq_two_on", 32'h1, {31'h0, irq_two});
    // old reload flags would make the capture irq check pass on their own
    wr(OFS_PENDING_REG, 32'hF, RESP_OKAY);
    wr(OFS_CLOCK_SELECT_REG, 32'h0, RESP_OKAY);
    wr(OFS_COUNTER_ONE, 32'h1234, RESP_OKAY);
    wr(OFS_MODE_CONTROL_REG, 32'hD51, RESP_OKAY);
    i_pad.set(1'b1, 1'b1);
    rd(OFS_RELOAD_CAPTURE_A, RESP_OKAY);
    chk("capture_a", 32'h1234, rd_v);
    rd(OFS_COUNTER_ONE, RESP_OKAY);
    chk("preset_one", 32'hFFFF, rd_v);
    wr(OFS_CLOCK_SELECT_REG, 32'h2, RESP_OKAY);
    i_pad.set(1'b0, 1'b0);
    rd(OFS_RELOAD_CAPTURE_B, RESP_OKAY);
    chk("capture_b", 32'hFFFF, rd_v);
    rd(OFS_RELOAD_CAPTURE_A, RESP_OKAY);
    chk("a_falling_ignored", 32'h1234, rd_v);
    rd(OFS_COUNTER_ONE, RESP_OKAY);
    chk("one_stopped", 32'hFFFF, rd_v);
    chk("irq_capture", 32'h1, {31'h0, irq_one});
    $display("test capture done");
    give_verdict;
  end
endmodule
